// ---- logic/dbg_serial_port.sv ----
// debug serial port: pin sequencing, serial shift logic and debug-entry handshake
// assumes the core answers halt requests with core_halted and supplies read data on request;
// serial logic runs on the controller's serial clock, which may stand still outside transfers
//
// Functional notes
// - serial input is sampled on falling serial clock edges
// - serial input words arrive most significant bit first
// - serial input is ignored until debug mode is entered
// - outside debug mode data-in and clock pins drive status; inputs after acknowledge
// - the two pins go high impedance when turned into inputs
// - status: 00 normal, 01 stop or wait, 10 core busy, 11 DMA busy
// - during reset data-in and clock pins are outputs driven low
// - shift in on falling edges, update serial output on rising edges
// - serial output is held high while the port is idle
// - read data ready is shown by a 2T low pulse on serial output
// - debug entry is acknowledged by a 1T low pulse on serial output; the code drives it low for one system clock, 2T
// - serial output data leaves most significant bit first
// - serial output is high throughout reset
// - serial output carries the register chosen by the latest command
// - debug request halts the core after its instruction, then awaits commands
// - an eight-bit command shift register stops after eight bits
// - five-bit falling-edge counter, cleared at reset and acknowledge, flags 8 and 32
`timescale 1ns/100ps
module dbg_serial_port #(
  parameter int CMD_BITS = dbg_port_pkg::CMD_BITS,
  parameter int WORD_BITS = dbg_port_pkg::WORD_BITS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic dbg_serial_clk,
  input wire logic dbg_serial_in,
  output logic chip_status_bit0,
  output logic chip_status_bit0_oe,
  output logic chip_status_bit1,
  output logic chip_status_bit1_oe,
  output logic dbg_serial_out,
  input wire logic dbg_request_n,
  input wire logic trace_break_event,
  input wire logic core_halted,
  input wire logic core_resume,
  input wire logic core_stop_wait,
  input wire logic core_busy,
  input wire logic dma_busy,
  input wire logic read_data_valid,
  input wire logic [WORD_BITS-1:0] read_data,
  output logic halt_req,
  output logic debug_mode,
  output logic cmd_valid,
  output logic [CMD_BITS-1:0] cmd_byte,
  output logic wr_data_valid,
  output logic [WORD_BITS-1:0] wr_data
);

  localparam int CNT_W = dbg_port_pkg::BIT_CNT_W;
  localparam int PULSE_CNT_W = dbg_port_pkg::PULSE_CNT_W;

  if (CMD_BITS < 2 || CMD_BITS >= WORD_BITS || WORD_BITS > (1 << CNT_W)) begin : g_bad_width
    $error("dbg_serial_port: word widths not served by the bit counter");
  end

  // ----------------------------------------------------------------
  // system-domain state
  // ----------------------------------------------------------------
  dbg_port_pkg::sys_state_t state_reg, state_next;
  logic [dbg_port_pkg::PULSE_CNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;
  logic pulse_n_reg;
  logic shift_sel_reg;
  logic in_en_reg;
  logic ack_tgl_reg;
  logic [WORD_BITS-1:0] rd_word_reg;
  logic [1:0] status_reg;
  logic oe_reg;
  logic halt_req_reg;
  logic debug_mode_reg;
  logic cmd_valid_reg;
  logic [CMD_BITS-1:0] cmd_byte_reg;
  logic wr_valid_reg;
  logic [WORD_BITS-1:0] wr_data_reg;
  logic [2:0] tgl_seen_reg;
  logic sclk_prev_reg;
  logic lk_rst_reg;

  // link-domain state
  dbg_port_pkg::link_phase_t lk_phase_reg;
  logic [CNT_W-1:0] shift_bit_counter;
  logic [CMD_BITS-1:0] cmd_shift_reg;
  logic [WORD_BITS-1:0] wdata_shift_reg;
  logic cmd_tgl_reg, word_tgl_reg, rd_tgl_reg;
  logic ack_seen_reg;
  logic [WORD_BITS-1:0] out_shift_reg;
  logic out_bit_reg;
  logic out_loaded_reg;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sys_sync_q;
  logic [1:0] link_sync_q;

  sync_2ff #(.WIDTH(5)) u_sys_sync (
    .clock(clock),
    .en(clock_en),
    .d({rd_tgl_reg, word_tgl_reg, cmd_tgl_reg, dbg_serial_clk, dbg_request_n}),
    .q(sys_sync_q)
  );

  // link side samples on falling edges, where the shift logic lives
  sync_2ff #(.WIDTH(2)) u_link_sync (
    .clock(~dbg_serial_clk),
    .en(1'b1),
    .d({ack_tgl_reg, in_en_reg}),
    .q(link_sync_q)
  );

  wire req_active = ~sys_sync_q[0];
  wire sclk_s = sys_sync_q[1];
  wire sclk_fall = sclk_prev_reg & ~sclk_s;
  wire cmd_done = sys_sync_q[2] ^ tgl_seen_reg[0];
  wire word_done = sys_sync_q[3] ^ tgl_seen_reg[1];
  wire rd_done = sys_sync_q[4] ^ tgl_seen_reg[2];
  wire lk_in_en = link_sync_q[0];
  wire lk_ack_evt = link_sync_q[1] ^ ack_seen_reg;

  // the link reset cannot wait for serial clock edges: the clock pin is driven low while reset lasts
  always_ff @(posedge clock) begin
    lk_rst_reg <= ~resetn;
  end

  // ----------------------------------------------------------------
  // status code and sequencing
  // ----------------------------------------------------------------
  wire [1:0] status_code = dma_busy ? dbg_port_pkg::STATUS_CORE_DMA_BUSY :
                           core_busy ? dbg_port_pkg::STATUS_CORE_BUSY :
                           core_stop_wait ? dbg_port_pkg::STATUS_STOP_WAIT :
                           dbg_port_pkg::STATUS_NORMAL;
  wire in_debug = (state_reg != dbg_port_pkg::ST_RUN) && (state_reg != dbg_port_pkg::ST_HALTING);
  wire leave_debug = in_debug && core_resume;
  wire pulse_last = (pulse_cnt_reg == '0);
  wire enter_ack = (state_reg == dbg_port_pkg::ST_HALTING) && core_halted;
  wire cmd_is_write = cmd_shift_reg[dbg_port_pkg::CMD_WRITE_BIT];
  wire pulse_low_next = (state_next == dbg_port_pkg::ST_ACK) || (state_next == dbg_port_pkg::ST_READY);
  wire drive_next = (state_next == dbg_port_pkg::ST_RUN) || (state_next == dbg_port_pkg::ST_HALTING);

  always_comb begin
    state_next = state_reg;
    pulse_cnt_next = pulse_cnt_reg;
    unique case (state_reg)
      dbg_port_pkg::ST_RUN: begin
        if (req_active || trace_break_event) begin
          state_next = dbg_port_pkg::ST_HALTING;
        end
      end
      dbg_port_pkg::ST_HALTING: begin
        if (core_halted) begin
          state_next = dbg_port_pkg::ST_ACK;
          pulse_cnt_next = PULSE_CNT_W'(dbg_port_pkg::ACK_CYCLES - 1);
        end
      end
      dbg_port_pkg::ST_ACK: begin
        pulse_cnt_next = pulse_cnt_reg - 1'b1;
        if (pulse_last) begin
          state_next = dbg_port_pkg::ST_CMD_WAIT;
        end
      end
      dbg_port_pkg::ST_CMD_WAIT: begin
        if (cmd_done) begin
          state_next = cmd_is_write ? dbg_port_pkg::ST_WDATA_WAIT : dbg_port_pkg::ST_READ_WAIT;
        end
      end
      dbg_port_pkg::ST_WDATA_WAIT: begin
        if (word_done) begin
          state_next = dbg_port_pkg::ST_CMD_WAIT;
        end
      end
      dbg_port_pkg::ST_READ_WAIT: begin
        if (read_data_valid) begin
          state_next = dbg_port_pkg::ST_READY;
          pulse_cnt_next = PULSE_CNT_W'(dbg_port_pkg::READY_CYCLES - 1);
        end
      end
      dbg_port_pkg::ST_READY: begin
        pulse_cnt_next = pulse_cnt_reg - 1'b1;
        if (pulse_last) begin
          state_next = dbg_port_pkg::ST_SHIFT_OUT;
        end
      end
      dbg_port_pkg::ST_SHIFT_OUT: begin
        if (rd_done) begin
          state_next = dbg_port_pkg::ST_CMD_WAIT;
        end
      end
    endcase
    if (leave_debug) begin
      state_next = dbg_port_pkg::ST_RUN;
    end
  end

  // reset acts even while the clock enable is low
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= dbg_port_pkg::ST_RUN;
      pulse_cnt_reg <= '0;
      pulse_n_reg <= 1'b1;
      shift_sel_reg <= 1'b0;
      in_en_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      oe_reg <= 1'b1;
      status_reg <= dbg_port_pkg::STATUS_NORMAL;
      halt_req_reg <= 1'b0;
      debug_mode_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else if (clock_en) begin
      state_reg <= state_next;
      pulse_cnt_reg <= pulse_cnt_next;
      pulse_n_reg <= ~pulse_low_next;
      shift_sel_reg <= (state_next == dbg_port_pkg::ST_SHIFT_OUT);
      in_en_reg <= (state_next != dbg_port_pkg::ST_RUN) && (state_next != dbg_port_pkg::ST_HALTING) &&
                   (state_next != dbg_port_pkg::ST_ACK);
      if (enter_ack) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
      // pins turn to inputs with the acknowledge and are released, not driven
      oe_reg <= drive_next;
      // gated here so that the status pins come straight from flops
      status_reg <= drive_next ? status_code : dbg_port_pkg::STATUS_NORMAL;
      halt_req_reg <= (state_next != dbg_port_pkg::ST_RUN);
      debug_mode_reg <= in_debug || enter_ack;
      sclk_prev_reg <= sclk_s;
    end
  end

  // toggles seen and words handed to the core
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tgl_seen_reg <= '0;
      cmd_valid_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      cmd_byte_reg <= '0;
      wr_data_reg <= '0;
      rd_word_reg <= '0;
    end else if (clock_en) begin
      tgl_seen_reg <= sys_sync_q[4:2];
      cmd_valid_reg <= cmd_done && (state_reg == dbg_port_pkg::ST_CMD_WAIT);
      wr_valid_reg <= word_done && (state_reg == dbg_port_pkg::ST_WDATA_WAIT);
      // link registers are stable here: the register that raised the toggle stops shifting once its count completes
      if (cmd_done) begin
        cmd_byte_reg <= cmd_shift_reg;
      end
      if (word_done) begin
        wr_data_reg <= wdata_shift_reg;
      end
      if (state_reg == dbg_port_pkg::ST_READ_WAIT && read_data_valid) begin
        rd_word_reg <= read_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: falling edges shift in and count
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] cnt_inc = shift_bit_counter + 1'b1;
  wire cmd_full = (cnt_inc == CNT_W'(CMD_BITS));
  wire word_full = (shift_bit_counter == CNT_W'(WORD_BITS - 1));

  always_ff @(negedge dbg_serial_clk or posedge lk_rst_reg) begin
    if (lk_rst_reg) begin
      shift_bit_counter <= '0;
      cmd_shift_reg <= '0;
      wdata_shift_reg <= '0;
      lk_phase_reg <= dbg_port_pkg::LK_IDLE;
      cmd_tgl_reg <= 1'b0;
      word_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else if (lk_ack_evt) begin
      // the clear lands on the next edge, so that edge is not a data bit
      ack_seen_reg <= ~ack_seen_reg;
      shift_bit_counter <= '0;
      lk_phase_reg <= dbg_port_pkg::LK_CMD;
    end else if (lk_in_en) begin
      unique case (lk_phase_reg)
        dbg_port_pkg::LK_CMD: begin
          cmd_shift_reg <= {cmd_shift_reg[CMD_BITS-2:0], dbg_serial_in};
          shift_bit_counter <= cmd_full ? '0 : cnt_inc;
          if (cmd_full) begin
            cmd_tgl_reg <= ~cmd_tgl_reg;
            lk_phase_reg <= cmd_shift_reg[CMD_BITS-2] ? dbg_port_pkg::LK_WDATA : dbg_port_pkg::LK_RDATA;
          end
        end
        dbg_port_pkg::LK_WDATA: begin
          wdata_shift_reg <= {wdata_shift_reg[WORD_BITS-2:0], dbg_serial_in};
          shift_bit_counter <= word_full ? '0 : cnt_inc;
          if (word_full) begin
            word_tgl_reg <= ~word_tgl_reg;
            lk_phase_reg <= dbg_port_pkg::LK_CMD;
          end
        end
        dbg_port_pkg::LK_RDATA: begin
          shift_bit_counter <= word_full ? '0 : cnt_inc;
          if (word_full) begin
            rd_tgl_reg <= ~rd_tgl_reg;
            lk_phase_reg <= dbg_port_pkg::LK_CMD;
          end
        end
        dbg_port_pkg::LK_IDLE: begin
          shift_bit_counter <= shift_bit_counter;
        end
      endcase
    end
  end

  // rising edges present the next output bit; the word is held still by the system side
  always_ff @(posedge dbg_serial_clk) begin
    if (lk_phase_reg != dbg_port_pkg::LK_RDATA) begin
      out_bit_reg <= 1'b1;
      out_loaded_reg <= 1'b0;
    end else if (!out_loaded_reg) begin
      out_bit_reg <= rd_word_reg[WORD_BITS-1];
      out_shift_reg <= {rd_word_reg[WORD_BITS-2:0], 1'b0};
      out_loaded_reg <= 1'b1;
    end else begin
      out_bit_reg <= out_shift_reg[WORD_BITS-1];
      out_shift_reg <= {out_shift_reg[WORD_BITS-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the serial output merges three flops: system pulses, link data and its select; high when neither source is active
  assign dbg_serial_out = pulse_n_reg & (out_bit_reg | ~shift_sel_reg);
  assign chip_status_bit0 = status_reg[0];
  assign chip_status_bit1 = status_reg[1];
  assign chip_status_bit0_oe = oe_reg;
  assign chip_status_bit1_oe = oe_reg;
  assign halt_req = halt_req_reg;
  assign debug_mode = debug_mode_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_byte = cmd_byte_reg;
  assign wr_data_valid = wr_valid_reg;
  assign wr_data = wr_data_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_pins_low: assert property (@(posedge clock)
    !resetn |=> chip_status_bit0_oe && chip_status_bit1_oe && !chip_status_bit0 && !chip_status_bit1)
    else $error("status pins not driven low after reset");

  a_reset_out_high: assert property (@(posedge clock)
    !resetn |=> dbg_serial_out)
    else $error("serial output not high during reset");

  a_pins_released: assert property (@(posedge clock) disable iff (!resetn)
    $rose(debug_mode_reg) |-> !chip_status_bit0_oe && !chip_status_bit1_oe && !dbg_serial_out)
    else $error("status pins still driven at debug entry");

  a_status_follows: assert property (@(posedge clock) disable iff (!resetn)
    (clock_en && state_reg == dbg_port_pkg::ST_RUN) |=> {chip_status_bit1, chip_status_bit0} == $past(status_code))
    else $error("status pins do not follow core state");

  a_ack_pulse: assert property (@(posedge clock) disable iff (!resetn || !clock_en)
    (enter_ack && !core_resume) |=> !dbg_serial_out ##1 dbg_serial_out)
    else $error("acknowledge pulse has wrong width");

  a_ready_pulse: assert property (@(posedge clock) disable iff (!resetn || !clock_en)
    (state_reg == dbg_port_pkg::ST_READ_WAIT && read_data_valid && !core_resume) |=> !dbg_serial_out [*1]
    ##1 (state_reg == dbg_port_pkg::ST_SHIFT_OUT || state_reg == dbg_port_pkg::ST_RUN))
    else $error("ready pulse has wrong width");

  a_idle_high: assert property (@(posedge clock) disable iff (!resetn)
    (state_reg == dbg_port_pkg::ST_CMD_WAIT && $past(state_reg) == dbg_port_pkg::ST_CMD_WAIT) |-> dbg_serial_out)
    else $error("serial output low while idle");

  a_halt_on_request: assert property (@(posedge clock) disable iff (!resetn)
    (clock_en && req_active && state_reg == dbg_port_pkg::ST_RUN) |=> halt_req ##0
    (state_reg == dbg_port_pkg::ST_HALTING))
    else $error("debug request did not halt the core");

  a_sclk_rate: assert property (@(posedge clock) disable iff (!resetn || !clock_en)
    sclk_fall |=> !sclk_fall [*2])
    else $error("serial clock faster than a third of system clock");

  a_input_ignored: assert property (@(negedge dbg_serial_clk) disable iff (lk_rst_reg)
    (!lk_in_en && !lk_ack_evt) |=> $stable(cmd_shift_reg))
    else $error("serial input taken outside debug mode");

  a_cmd_stops: assert property (@(negedge dbg_serial_clk) disable iff (lk_rst_reg)
    (lk_phase_reg != dbg_port_pkg::LK_CMD) |=> $stable(cmd_shift_reg))
    else $error("command register shifted past eight bits");

endmodule

// ---- include/dbg_port_pkg.sv ----
// constants for the debug serial port: timing, widths, status codes
// assumes a system clock of 25 MHz and T equal to half the master-clock period
package dbg_port_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS = 40;
  localparam int MASTER_CLK_NS = 40;
  localparam int T_NS = MASTER_CLK_NS / 2;
  localparam int ACK_T = 1;
  localparam int READY_T = 2;
  // least times: round up, never below one cycle
  localparam int ACK_CYCLES_RAW = (ACK_T * T_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int ACK_CYCLES = (ACK_CYCLES_RAW < 1) ? 1 : ACK_CYCLES_RAW;
  localparam int READY_CYCLES_RAW = (READY_T * T_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int READY_CYCLES = (READY_CYCLES_RAW < 1) ? 1 : READY_CYCLES_RAW;
  localparam int PULSE_CNT_W = 4;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int WORD_BITS = 32;
  localparam int BIT_CNT_W = 5;
  localparam int CMD_WRITE_BIT = 7;

  // ----------------------------------------------------------------
  // chip status codes on {status1, status0}
  // ----------------------------------------------------------------
  localparam logic [1:0] STATUS_NORMAL = 2'h0;
  localparam logic [1:0] STATUS_STOP_WAIT = 2'h1;
  localparam logic [1:0] STATUS_CORE_BUSY = 2'h2;
  localparam logic [1:0] STATUS_CORE_DMA_BUSY = 2'h3;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HALTING = 3'b001,
    ST_ACK = 3'b010,
    ST_CMD_WAIT = 3'b011,
    ST_WDATA_WAIT = 3'b100,
    ST_READ_WAIT = 3'b101,
    ST_READY = 3'b110,
    ST_SHIFT_OUT = 3'b111
  } sys_state_t;

  typedef enum logic [1:0] {
    LK_CMD = 2'b00,
    LK_WDATA = 2'b01,
    LK_RDATA = 2'b10,
    LK_IDLE = 2'b11
  } link_phase_t;

endpackage

// ---- logic/sync_2ff.sv ----
// two-flop synchroniser for levels and toggles
// assumes the inputs are levels or toggles held at least two destination clocks
`timescale 1ns/100ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // the first stage is read by the second stage only
  always_ff @(posedge clock) begin
    if (en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- bench/dbg_ctrl_model.sv ----
// external debug controller: makes the serial clock, sends serial words, reads serial output
// assumes lclk is a free 64 ns clock and that the caller only clocks while the device has released the pins
`timescale 1ns/100ps
module dbg_ctrl_model (
  input wire logic lclk,
  input wire logic sdo,
  output logic sclk_drv,
  output logic sdi_drv,
  output logic drive_en
);
  // ------------------------------------------------------------------
  // serial clock: one lclk per half period, so 128 ns, under a third of the system clock
  // ------------------------------------------------------------------
  initial begin
    sclk_drv = 1'h0;
    sdi_drv = 1'h0;
    drive_en = 1'h0;
  end

  task automatic attach(input logic en);
    @(posedge lclk);
    drive_en = en;
  endtask

  // data changes with the rising edge, the device takes it on the falling one
  task automatic send_bits(input int n, input logic [31:0] value);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge lclk);
      sdi_drv = value[i];
      sclk_drv = 1'h1;
      @(posedge lclk);
      sclk_drv = 1'h0;
    end
    @(posedge lclk);
    // hold time over: the line no longer shows the last bit
    sdi_drv = ~sdi_drv;
  endtask

  task automatic get_bits(input int n, output logic [31:0] value);
    value = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge lclk);
      sclk_drv = 1'h1;
      sdi_drv = ~sdi_drv;
      @(negedge lclk);
      value = {value[30:0], sdo};
      @(posedge lclk);
      sclk_drv = 1'h0;
    end
  endtask
endmodule

// ---- bench/testbench.sv ----
// testbench for the debug serial port: status pins, debug entry, commands, write and read words
// assumes the controller model in dbg_ctrl_model and a pull-down on both shared pins
`timescale 1ns/100ps
module testbench;
  logic clock, resetn, lclk, dbg_request_n, trace_break_event, core_halted, core_resume;
  logic core_stop_wait, core_busy, dma_busy, read_data_valid;
  logic s0, s0_oe, s1, s1_oe, sdo, halt_req, debug_mode, cmd_valid, wr_data_valid;
  logic sclk_drv, sdi_drv, drive_en;
  logic [7:0] cmd_byte;
  logic [31:0] read_data, wr_data, got;
  wire sclk_pin, sdi_pin;
  int n_errors = 0;
  int num_checks = 0;

  // pull-down when nobody drives; both sides driving shows as unknown
  assign sclk_pin = s1_oe ? (drive_en ? 1'hx : s1) : (drive_en ? sclk_drv : 1'h0);
  assign sdi_pin = s0_oe ? (drive_en ? 1'hx : s0) : (drive_en ? sdi_drv : 1'h0);

  always #20 clock = ~clock;

  initial begin
    lclk = 1'h0;
    #7;
    forever #32 lclk = ~lclk;
  end

  dbg_serial_port uut (.clock(clock), .resetn(resetn), .clock_en(1'h1), .dbg_serial_clk(sclk_pin),
    .dbg_serial_in(sdi_pin), .chip_status_bit0(s0), .chip_status_bit0_oe(s0_oe), .chip_status_bit1(s1),
    .chip_status_bit1_oe(s1_oe), .dbg_serial_out(sdo), .dbg_request_n(dbg_request_n),
    .trace_break_event(trace_break_event), .core_halted(core_halted), .core_resume(core_resume),
    .core_stop_wait(core_stop_wait), .core_busy(core_busy), .dma_busy(dma_busy),
    .read_data_valid(read_data_valid), .read_data(read_data), .halt_req(halt_req), .debug_mode(debug_mode),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_data_valid(wr_data_valid), .wr_data(wr_data));

  dbg_ctrl_model ctrl (.lclk(lclk), .sdo(sdo), .sclk_drv(sclk_drv), .sdi_drv(sdi_drv), .drive_en(drive_en));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_bit(input string what, input logic exp, input logic seen);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask

  task automatic wait_for(input int sel, input string what);
    int n;
    n = 0;
    while (n < 400 && !((sel == 0 && halt_req === 1'h1) || (sel == 1 && cmd_valid === 1'h1)
        || (sel == 2 && wr_data_valid === 1'h1))) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) begin
      $display("CHECK FAILED %s expected pulse seen none", what);
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic count_low(input int cycles, output int lows);
    lows = 0;
    repeat (cycles) begin
      @(negedge clock);
      if (sdo === 1'h0) lows++;
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_status;
    logic [2:0] cause [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    logic [1:0] code [5] = '{dbg_port_pkg::STATUS_NORMAL, dbg_port_pkg::STATUS_STOP_WAIT,
      dbg_port_pkg::STATUS_CORE_BUSY, dbg_port_pkg::STATUS_CORE_DMA_BUSY, dbg_port_pkg::STATUS_CORE_BUSY};
    for (int i = 0; i < 5; i++) begin
      {dma_busy, core_busy, core_stop_wait} = cause[i];
      repeat (3) @(negedge clock);
      check_word("status code", {30'h0, code[i]}, {30'h0, sclk_pin, sdi_pin});
    end
    {dma_busy, core_busy, core_stop_wait} = 3'h0;
    $display("test status done");
  endtask

  task automatic test_entry(input logic by_trace);
    int lows;
    if (by_trace) trace_break_event = 1'h1;
    else dbg_request_n = 1'h0;
    wait_for(0, "halt request");
    trace_break_event = 1'h0;
    check_bit("debug mode before halt", 1'h0, debug_mode);
    core_halted = 1'h1;
    count_low(8, lows);
    check_word("ack low cycles", 32'(dbg_port_pkg::ACK_CYCLES), 32'(lows));
    check_bit("debug mode", 1'h1, debug_mode);
    check_word("pin drives", 32'h0, {30'h0, s1_oe, s0_oe});
    check_word("released pins", 32'h0, {30'h0, sclk_pin, sdi_pin});
    dbg_request_n = 1'h1;
    ctrl.attach(1'h1);
    // let the ack cross to the link side and clear the bit counter
    ctrl.send_bits(3, 32'h0);
    $display("test entry done");
  endtask

  task automatic test_write;
    fork
      ctrl.send_bits(8, 32'h0000_00A5);
      wait_for(1, "command strobe");
    join
    check_word("write command", 32'h0000_00A5, {24'h0, cmd_byte});
    fork
      ctrl.send_bits(32, 32'h1234_5678);
      wait_for(2, "write strobe");
    join
    check_word("write word", 32'h1234_5678, wr_data);
    check_bit("idle serial out", 1'h1, sdo);
    $display("test write done");
  endtask

  task automatic test_read;
    int lows;
    fork
      ctrl.send_bits(8, 32'h0000_002C);
      wait_for(1, "command strobe");
    join
    check_word("read command", 32'h0000_002C, {24'h0, cmd_byte});
    repeat (2) @(negedge clock);
    read_data_valid = 1'h1;
    read_data = 32'hC3A5_0F96;
    // valid stays up while counting: the ready pulse starts on the very next edge
    count_low(8, lows);
    read_data_valid = 1'h0;
    check_word("ready low cycles", 32'(dbg_port_pkg::READY_CYCLES), 32'(lows));
    ctrl.get_bits(32, got);
    check_word("read word", 32'hC3A5_0F96, got);
    repeat (4) @(negedge clock);
    check_bit("idle after read", 1'h1, sdo);
    $display("test read done");
  endtask

  task automatic test_resume;
    ctrl.attach(1'h0);
    @(negedge clock);
    core_resume = 1'h1;
    core_halted = 1'h0;
    @(negedge clock);
    core_resume = 1'h0;
    repeat (3) @(negedge clock);
    check_word("leave debug", 32'h0, {30'h0, halt_req, debug_mode});
    check_word("pins driven again", 32'h3, {30'h0, s1_oe, s0_oe});
    $display("test resume done");
  endtask

  initial begin
    clock = 1'h0;
    resetn = 1'h0;
    {dbg_request_n, trace_break_event, core_halted, core_resume} = 4'h8;
    {core_stop_wait, core_busy, dma_busy, read_data_valid} = 4'h0;
    read_data = 32'h0;
    repeat (2) @(negedge clock);
    check_word("reset pins", 32'h3, {30'h0, s1_oe, s0_oe});
    check_word("reset levels", 32'h0, {30'h0, sclk_pin, sdi_pin});
    check_bit("reset serial out", 1'h1, sdo);
    repeat (2) @(negedge clock);
    resetn = 1'h1;
    $display("test reset done");
    test_status();
    test_entry(1'h0);
    test_write();
    test_read();
    test_resume();
    test_entry(1'h1);
    test_write();
    test_resume();
    report_and_stop();
  end
endmodule
